// ---- design/bsc_cell_chain.sv ----
// Purpose: boundary cell chain with capture, shift and update stages
// Assumes: enables are one-cycle pulses taken at test clock rising edges
// Notes: cell 0 is nearest the serial output
`timescale 1ns/1ps
`include "bsc_consts.svh"

module bsc_cell_chain (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic test_rst_in,
  input wire logic capture_in,
  input wire logic shift_in,
  input wire logic update_in,
  input wire logic serial_in,
  input wire logic [`BSC_CELLS-1:0] parallel_in,
  output logic serial_out,
  output logic [`BSC_CELLS-1:0] update_out
);
  import bsc_pkg::*;

  logic [`BSC_CELLS-1:0] shift_r;
  logic [`BSC_CELLS-1:0] update_r;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= '0;
    end else if (capture_in) begin
      shift_r <= parallel_in;
    end else if (shift_in) begin
      shift_r <= {serial_in, shift_r[`BSC_CELLS-1:1]};
    end
  end

  // update stage keeps the last loaded value and clears on test reset; the shift stage does not
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      update_r <= '0;
    end else if (test_rst_in) begin
      update_r <= '0;
    end else if (update_in) begin
      update_r <= shift_r;
    end
  end

  assign serial_out = shift_r[0];
  assign update_out = update_r;

endmodule : bsc_cell_chain

// ---- design/bsc_consts.svh ----
// Purpose: named constants for the boundary-scan test port
// Assumes: included by its bare name wherever a constant is needed
// Notes: definitions only
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

`define BSC_CELLS 268
`define BSC_IR_W 4
`define BSC_ID_W 32
`define BSC_IR_PIN_TEST 4'h0
`define BSC_IR_SAMPLE 4'h1
`define BSC_IR_READ_ID 4'h2
`define BSC_IR_HIGHZ 4'h3
`define BSC_IR_BYPASS 4'hF
`define BSC_IR_CAPTURE 4'h1
`define BSC_ID_MARK 1'b1
// arbitrary neutral identity values
`define BSC_ID_REV 4'h1
`define BSC_ID_DEV 16'h5A5A
`define BSC_ID_VEN 11'h2A5
// cell layout: data pins as out/ctl/in triples, tx pins as out/ctl pairs
`define BSC_TRI_FIRST 26
`define BSC_TRI_LAST 75
`define BSC_PAIR_GROUPS {9'd84, 9'd116, 9'd132, 9'd164, 9'd180, 9'd212, 9'd228, 9'd260}

`endif

// ---- design/bsc_pkg.sv ----
// Purpose: types and shared decoding for the boundary-scan test port
// Assumes: bsc_consts.svh supplies the numeric constants
// Notes: the cell-kind function is used by the top only, not by the chain
`include "bsc_consts.svh"

package bsc_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } bsc_tap_state_t;

  typedef enum logic [1:0] {
    CELL_IN, CELL_OUT, CELL_CTL
  } bsc_cell_kind_t;

  // kind of boundary cell i; output cells are followed by their control cell
  function automatic bsc_cell_kind_t bsc_cell_kind(input int i);
    logic [71:0] groups;
    int lo;
    int hi;
    bsc_cell_kind_t k;
    groups = `BSC_PAIR_GROUPS;
    k = CELL_IN;
    if (i >= `BSC_TRI_FIRST && i <= `BSC_TRI_LAST) begin
      if ((i - `BSC_TRI_FIRST) % 3 == 0) begin
        k = CELL_OUT;
      end else if ((i - `BSC_TRI_FIRST) % 3 == 1) begin
        k = CELL_CTL;
      end
    end
    // odd-numbered groups of the list (84..115, 132..163, ...) are tx pairs
    for (int g = 0; g < 8; g += 2) begin
      hi = int'(groups[(71 - 9 * g) -: 9]);
      lo = int'(groups[(71 - 9 * (g + 1)) -: 9]);
      if (i >= hi && i < lo) begin
        k = ((i - hi) % 2 == 0) ? CELL_OUT : CELL_CTL;
      end
    end
    return k;
  endfunction : bsc_cell_kind

endpackage : bsc_pkg

// ---- design/bsc_test_port.sv ----
// Purpose: boundary-scan test access port sampled by the system clock
// Assumes: test clock is far slower than mclk_in (about 8 samples a period)
// Notes: pins pass a two-stage synchroniser; pad outputs lag the core by one cycle
`timescale 1ns/1ps
`include "bsc_consts.svh"

module bsc_test_port (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_drv_in,
  input wire logic tdi_in,
  input wire logic tdi_drv_in,
  input wire logic trst_n_in,
  input wire logic trst_drv_in,
  input wire logic [`BSC_CELLS-1:0] pad_in_in,
  input wire logic [`BSC_CELLS-1:0] core_out_in,
  input wire logic [`BSC_CELLS-1:0] core_oe_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [`BSC_CELLS-1:0] pad_out_out,
  output logic [`BSC_CELLS-1:0] pad_oe_out,
  output bsc_pkg::bsc_tap_state_t tap_state_out,
  output logic [`BSC_IR_W-1:0] ir_out
);
  import bsc_pkg::*;

  localparam int SW = 7;

  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic tck_prev_r;
  logic [`BSC_CELLS-1:0] pad_sync1_r;
  logic [`BSC_CELLS-1:0] pad_sync2_r;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  logic tck_rise;
  logic tck_fall;
  bsc_tap_state_t state_r;
  bsc_tap_state_t state_nxt;
  logic [`BSC_IR_W-1:0] ir_shift_r;
  logic [`BSC_IR_W-1:0] ir_r;
  logic bypass_r;
  logic [`BSC_ID_W-1:0] id_r;
  logic chain_so;
  logic [`BSC_CELLS-1:0] cell_upd;
  logic [`BSC_CELLS-1:0] cell_cap;
  logic sel_chain;
  logic sel_id;
  logic pin_test;
  logic highz;
  logic serial_sel;
  logic tdo_r;
  logic tdo_oe_r;
  logic [`BSC_CELLS-1:0] pad_out_r;
  logic [`BSC_CELLS-1:0] pad_oe_r;

  // sync1 feeds sync2 only; pull-ups are applied after the second stage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // idle pulled-up levels, so no false test clock edge follows reset
      sync1_r <= '1;
      sync2_r <= '1;
      tck_prev_r <= 1'b1;
    end else begin
      sync1_r <= {tck_in, tms_in, tms_drv_in, tdi_in, tdi_drv_in, trst_n_in, trst_drv_in};
      sync2_r <= sync1_r;
      tck_prev_r <= sync2_r[6];
    end
  end

  assign tck_s = sync2_r[6];
  assign tms_s = sync2_r[4] ? sync2_r[5] : 1'b1;
  assign tdi_s = sync2_r[2] ? sync2_r[3] : 1'b1;
  assign trst_s = sync2_r[0] ? sync2_r[1] : 1'b1;
  assign tck_rise = tck_s & ~tck_prev_r;
  assign tck_fall = ~tck_s & tck_prev_r;

  // pin levels for input cells come from outside the clock domain
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_sync1_r <= '0;
      pad_sync2_r <= '0;
    end else begin
      pad_sync1_r <= pad_in_in;
      pad_sync2_r <= pad_sync1_r;
    end
  end

  function automatic bsc_tap_state_t tap_next(input bsc_tap_state_t s, input logic m);
    bsc_tap_state_t n;
    n = s;
    unique case (s)
      TEST_LOGIC_RESET: n = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: n = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: n = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: n = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: n = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: n = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: n = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: n = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: n = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: n = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: n = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: n = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: n = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: n = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: n = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: n = m ? SELECT_DR : RUN_TEST_IDLE;
    endcase
    return n;
  endfunction : tap_next

  assign state_nxt = tap_next(state_r, tms_s);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= TEST_LOGIC_RESET;
    end else if (!trst_s) begin
      state_r <= TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // instruction path; reset selects the identity register as usual
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_shift_r <= `BSC_IR_CAPTURE;
      ir_r <= `BSC_IR_READ_ID;
    end else if (!trst_s || state_r == TEST_LOGIC_RESET) begin
      ir_shift_r <= `BSC_IR_CAPTURE;
      ir_r <= `BSC_IR_READ_ID;
    end else if (tck_rise) begin
      if (state_r == CAPTURE_IR) begin
        ir_shift_r <= `BSC_IR_CAPTURE;
      end else if (state_r == SHIFT_IR) begin
        ir_shift_r <= {tdi_s, ir_shift_r[`BSC_IR_W-1:1]};
      end else if (state_r == UPDATE_IR) begin
        ir_r <= ir_shift_r;
      end
    end
  end

  // reserved codes fall through to the bypass path
  assign pin_test = (ir_r == `BSC_IR_PIN_TEST);
  assign sel_chain = pin_test || (ir_r == `BSC_IR_SAMPLE);
  assign sel_id = (ir_r == `BSC_IR_READ_ID);
  assign highz = (ir_r == `BSC_IR_HIGHZ);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bypass_r <= 1'b0;
      id_r <= '0;
    end else if (!trst_s) begin
      bypass_r <= 1'b0;
      id_r <= '0;
    end else if (tck_rise) begin
      if (state_r == CAPTURE_DR) begin
        bypass_r <= 1'b0;
        id_r <= {`BSC_ID_REV, `BSC_ID_DEV, `BSC_ID_VEN, `BSC_ID_MARK};
      end else if (state_r == SHIFT_DR) begin
        bypass_r <= tdi_s;
        if (sel_id) begin
          id_r <= {tdi_s, id_r[`BSC_ID_W-1:1]};
        end
      end
    end
  end

  // capture pin levels for input cells, driven values for output and control cells
  always_comb begin
    cell_cap = pad_sync2_r;
    for (int i = 0; i < `BSC_CELLS; i++) begin
      if (bsc_cell_kind(i) == CELL_OUT) begin
        cell_cap[i] = pad_out_r[i];
      end else if (bsc_cell_kind(i) == CELL_CTL) begin
        cell_cap[i] = pad_oe_r[i - 1];
      end
    end
  end

  bsc_cell_chain u_chain (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .test_rst_in(!trst_s || state_r == TEST_LOGIC_RESET),
    .capture_in(tck_rise && sel_chain && state_r == CAPTURE_DR),
    .shift_in(tck_rise && sel_chain && state_r == SHIFT_DR),
    .update_in(tck_rise && sel_chain && state_r == UPDATE_DR),
    .serial_in(tdi_s),
    .parallel_in(cell_cap),
    .serial_out(chain_so),
    .update_out(cell_upd)
  );

  always_comb begin
    if (state_r == SHIFT_IR) begin
      serial_sel = ir_shift_r[0];
    end else if (sel_chain) begin
      serial_sel = chain_so;
    end else if (sel_id) begin
      serial_sel = id_r[0];
    end else begin
      serial_sel = bypass_r;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (!trst_s) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= serial_sel;
      tdo_oe_r <= (state_r == SHIFT_IR) || (state_r == SHIFT_DR);
    end
  end

  // core values pass unless pin test is current; high-z also forces the output enables off
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
    end else begin
      for (int i = 0; i < `BSC_CELLS; i++) begin
        if (bsc_cell_kind(i) == CELL_OUT) begin
          pad_out_r[i] <= pin_test ? cell_upd[i] : core_out_in[i];
          if (highz) begin
            pad_oe_r[i] <= 1'b0;
          end else begin
            pad_oe_r[i] <= pin_test ? cell_upd[i + 1] : core_oe_in[i];
          end
        end else begin
          pad_out_r[i] <= 1'b0;
          pad_oe_r[i] <= 1'b0;
        end
      end
    end
  end

  assign tdo_out = tdo_r;
  assign tdo_oe_out = tdo_oe_r;
  assign pad_out_out = pad_out_r;
  assign pad_oe_out = pad_oe_r;
  assign tap_state_out = state_r;
  assign ir_out = ir_r;

endmodule : bsc_test_port

// ---- verif/boundary_scan_test_port_bench.sv ----
// Purpose: self-checking bench for the test port
// Assumes: partner model drives the scan pins
// Notes: inputs change 1 ns after mclk_in rises
`timescale 1ns/1ps
`include "bsc_consts.svh"
module boundary_scan_test_port_bench;
  import bsc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, q;
  logic trst_n = 1'b1;
  logic trst_drv = 1'b0;
  logic [267:0] pad_in = {134{2'b10}};
  logic [267:0] core_out = {134{2'b01}};
  logic [267:0] core_oe = '1;
  logic [267:0] pad_out, pad_oe, din, dout;
  bsc_tap_state_t st;
  logic [3:0] ir;
  int mismatches = 0;
  int num_checks = 0;
  always #50 mclk = ~mclk;
  bsc_test_port dut (.mclk_in(mclk), .rst_in(rst), .tck_in(tck), .tms_in(tms), .tms_drv_in(tms_drv),
    .tdi_in(tdi), .tdi_drv_in(tdi_drv), .trst_n_in(trst_n), .trst_drv_in(trst_drv), .pad_in_in(pad_in),
    .core_out_in(core_out), .core_oe_in(core_oe), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .pad_out_out(pad_out), .pad_oe_out(pad_oe), .tap_state_out(st), .ir_out(ir));
  // an undriven serial output reads as high impedance, so a missing enable shows up as a mismatch
  bsc_tester u_tst (.mclk_in(mclk), .tdo_in(tdo_oe ? tdo : 1'bz), .tck_out(tck), .tms_out(tms), .tms_drv_out(tms_drv),
    .tdi_out(tdi), .tdi_drv_out(tdi_drv));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic load_ir(input logic [3:0] c);
    din = '0;
    din[3:0] = c;
    u_tst.scan(1'b1, 4, din, dout);
  endtask : load_ir
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic t_read_id();
    chk("reset state", TEST_LOGIC_RESET, st);
    chk("reset ir", `BSC_IR_READ_ID, ir);
    u_tst.step(1'b0, 1'b0, 1'b0, q);
    u_tst.scan(1'b0, 32, '0, dout);
    chk("id", {`BSC_ID_REV, `BSC_ID_DEV, `BSC_ID_VEN, 1'b1}, dout[31:0]);
  endtask : t_read_id
  task automatic t_bypass(input logic [3:0] c);
    load_ir(c);
    chk("ir capture", 4'h1, dout[3:0]);
    chk("ir", c, ir);
    u_tst.scan(1'b0, 8, 268'hA5, dout);
    chk("bypass", 8'h4A, dout[7:0]);
    chk("tdo idle", 1'b0, tdo_oe);
  endtask : t_bypass
  task automatic t_highz();
    load_ir(`BSC_IR_HIGHZ);
    chk("highz oe", 1'b0, |pad_oe);
    load_ir(`BSC_IR_SAMPLE);
    chk("core path", {core_out[26], core_out[29], core_oe[26]}, {pad_out[26], pad_out[29], pad_oe[26]});
  endtask : t_highz
  task automatic t_chain();
    din = '0;
    din[27] = 1'b1;
    din[29] = 1'b1;
    u_tst.scan(1'b0, 268, din, dout);
    chk("sample", pad_in[25:0], dout[25:0]);
    chk("sample out", {core_out[29], pad_in[28], core_oe[26], core_out[26]}, dout[29:26]);
    load_ir(`BSC_IR_PIN_TEST);
    chk("pin test", 4'b0110, {pad_out[26], pad_oe[26], pad_out[29], pad_oe[29]});
  endtask : t_chain
  task automatic t_trst();
    trst_drv = 1'b1;
    trst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("trst", {TEST_LOGIC_RESET, `BSC_IR_READ_ID}, {st, ir});
    trst_n = 1'b1;
    trst_drv = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : t_trst
  task automatic t_pullup();
    u_tst.step(1'b0, 1'b0, 1'b0, q);
    u_tst.step(1'b1, 1'b0, 1'b0, q);
    chk("select", SELECT_DR, st);
    // pin left floating, low level on the wire must be ignored
    u_tst.tms_drv_out = 1'b0;
    for (int i = 0; i < 5; i++) u_tst.step(1'b0, 1'b0, 1'b0, q);
    chk("pullup", TEST_LOGIC_RESET, st);
  endtask : t_pullup
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1 t_read_id();
    t_bypass(`BSC_IR_BYPASS);
    t_bypass(4'h7);
    t_highz();
    t_chain();
    t_trst();
    t_pullup();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
endmodule : boundary_scan_test_port_bench

// ---- verif/bsc_props.sv ----
// Purpose: timing checks on the test port pins
// Assumes: test clock pin is sampled by mclk_in through two flops
// Notes: bound to bsc_test_port
`timescale 1ns/1ps
`include "bsc_consts.svh"
module bsc_props
  import bsc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tck_in,
  input wire logic trst_n_in,
  input wire logic trst_drv_in,
  input wire logic [`BSC_CELLS-1:0] core_out_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic [`BSC_CELLS-1:0] pad_out_out,
  input wire logic [`BSC_CELLS-1:0] pad_oe_out,
  input wire bsc_pkg::bsc_tap_state_t tap_state_out,
  input wire logic [`BSC_IR_W-1:0] ir_out
);
  // undriven reset pin floats high
  wire logic trst_eff;
  assign trst_eff = trst_n_in | ~trst_drv_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // two sync stages plus the edge detector put the reaction three edges after the pin
  sequence s_rise; !$past(tck_in, 4) && $past(tck_in, 3); endsequence
  sequence s_fall; $past(tck_in, 4) && !$past(tck_in, 3); endsequence
  sequence s_trst_low; !trst_eff [*4]; endsequence
  property p_state_on_rise;
    (!$stable(tap_state_out) && $past(trst_eff, 3) && $past(trst_eff, 4)) |-> s_rise;
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off a rise");
  property p_oe_rise; $rose(tdo_oe_out) |-> s_fall; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("output enable off a fall");
  property p_tdo_fall; (!$stable(tdo_out) && $past(tdo_oe_out) && tdo_oe_out) |-> s_fall; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off a fall");
  property p_oe_shift;
    tdo_oe_out |-> tap_state_out inside {SHIFT_DR, SHIFT_IR, EXIT1_DR, EXIT1_IR};
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("serial out driven outside shift");
  // the controller has already left the update state when the new code shows
  property p_ir_change;
    !$stable(ir_out) |-> ($past(tap_state_out) inside {UPDATE_IR, TEST_LOGIC_RESET}) ||
      (tap_state_out == TEST_LOGIC_RESET);
  endproperty
  a_ir_change: assert property (p_ir_change) else $error("instruction changed out of update");
  property p_trst;
    s_trst_low |-> tap_state_out == TEST_LOGIC_RESET && ir_out == `BSC_IR_READ_ID && !tdo_oe_out;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset not taken");
  property p_highz; ir_out == `BSC_IR_HIGHZ |=> pad_oe_out == '0; endproperty
  a_highz: assert property (p_highz) else $error("driver on under high-z");
  property p_core;
    ir_out inside {`BSC_IR_SAMPLE, `BSC_IR_READ_ID, `BSC_IR_BYPASS} |=> pad_out_out[26] == $past(core_out_in[26]);
  endproperty
  a_core: assert property (p_core) else $error("core path disturbed");
  property p_input_cells; pad_oe_out[25:0] == '0 && pad_out_out[25:0] == '0; endproperty
  a_input_cells: assert property (p_input_cells) else $error("input cell drives a pad");
endmodule : bsc_props
bind bsc_test_port bsc_props u_props (.mclk_in, .rst_in, .tck_in, .trst_n_in, .trst_drv_in, .core_out_in,
  .tdo_out, .tdo_oe_out, .pad_out_out, .pad_oe_out, .tap_state_out, .ir_out);

// ---- verif/bsc_tester.sv ----
// Purpose: external test controller model
// Assumes: tasks entered 1 ns after an mclk_in rise
// Notes: test clock stands high between frames
`timescale 1ns/1ps
module bsc_tester (
  input wire logic mclk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tms_drv_out,
  output logic tdi_out,
  output logic tdi_drv_out
);
  initial begin
    tck_out = 1'b1;
    tms_out = 1'b1;
    tms_drv_out = 1'b1;
    tdi_out = 1'b0;
    tdi_drv_out = 1'b0;
  end
  // one 800 ns period; tdo taken just before the rise
  task automatic step(input logic m, input logic d, input logic drv, output logic q);
    tms_out = m;
    // released line must not keep a stale value
    tdi_out = drv ? d : ~tdi_out;
    tdi_drv_out = drv;
    tck_out = 1'b0;
    repeat (4) @(posedge mclk_in);
    #1 q = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask : step
  // run-test-idle to run-test-idle through one scan
  task automatic scan(input logic ir, input int n, input logic [267:0] din, output logic [267:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, 1'b0, q);
    if (ir) step(1'b1, 1'b0, 1'b0, q);
    step(1'b0, 1'b0, 1'b0, q);
    step(1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, 1'b0, q);
    step(1'b0, 1'b0, 1'b0, q);
  endtask : scan
endmodule : bsc_tester
